// file: hdl/wwdt_pkg.sv
// Purpose: Constants for the windowed watchdog timer
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses within the block
package wwdt_pkg;
  // Register map
  localparam logic [15:0] ADDR_RESTART_KEY = 16'hFF99;
  localparam logic [15:0] OFF_RESTART_KEY  = 16'h0000;
  localparam logic [15:0] OFF_OPTION       = 16'h0004;
  localparam logic [15:0] OFF_CONTROL      = 16'h0008;
  localparam logic [15:0] OFF_STATUS       = 16'h000C;
  localparam logic [15:0] OFF_COUNT        = 16'h0010;
  // Restart key values
  localparam logic [7:0]  KEY_VALUE        = 8'hAC;
  localparam logic [7:0]  KEY_READ_RUN     = 8'h9A;
  localparam logic [7:0]  KEY_READ_IDLE    = 8'h1A;
  // Option byte fields
  localparam int          OPT_LOCK_BIT     = 0;
  localparam int          OPT_PERIOD_LSB   = 1;
  localparam int          OPT_RUN_BIT      = 4;
  localparam int          OPT_WIN_LSB      = 5;
  localparam logic [7:0]  OPT_RESET        = 8'h00;
  // Control bits
  localparam int          CTL_OSC_STOP_BIT = 1;
  localparam int          CTL_STANDBY_BIT  = 2;
  localparam int          CTL_BITOP_BIT    = 3;
  // Status bits
  localparam int          STS_RESET_FLAG   = 4;
  // Exempt data ranges
  localparam logic [15:0] EXEMPT_A_LO      = 16'hFB00;
  localparam logic [15:0] EXEMPT_A_HI      = 16'hFFCF;
  localparam logic [15:0] EXEMPT_B_LO      = 16'hFFE0;
  // Timing and AXI response codes
  localparam int          CLK_HZ           = 20000000;
  localparam int          LS_HZ_DEFAULT    = 264000;
  localparam int          LS_DIV_DEFAULT   = CLK_HZ / LS_HZ_DEFAULT;
  localparam int          PERIOD_LOG_MIN   = 10;
  localparam int          RST_PULSE_CYCLES = 4;
  localparam logic [1:0]  AXI_OKAY         = 2'h0;
  localparam logic [1:0]  AXI_SLVERR       = 2'h2;
endpackage : wwdt_pkg

// file: hdl/wwdt_top.sv
// Purpose: Windowed watchdog timer with AXI4-Lite register slave
// Assumes: Low-speed clock is an enable pulse divided from aclk
// Notes:   Memory ranges come in as ports from the memory-size unit
// Contract
// - Byte write of key ACH, legal to the window, clears and restarts count
// - Restart register resets to 9AH with run option 1, else 1AH
// - Non-key write resets device; deferred while low-speed clock stopped
// - Single-bit access to restart register resets device; deferred likewise
// - Restart register reads 9AH or 1AH per run option, never written value
// - Run option enables counting and illegal-access detection
// - Restart write in the closed window resets device, except the first after reset
// - Counter reaching overflow time without key write resets device
// - Fetch outside configured areas resets device while detection on
// - Data access outside areas resets device; FB00-FFCF, FFE0-FFFF exempt
// - First restart write after reset clears counter regardless of window
// - Overflow time after clear may differ by up to two low-speed periods
// - Key write just before overflow still clears counter
// - Lock option 0 halts count in standby, resumes without clear
// - Lock option 0 and oscillator stop bit stop counter without clear
// - Counting continues during flash self-programming
// - Period field codes 0..7 select 2^10..2^17 low-speed periods
// - Window field selects open fraction 25, 50, 75 or 100 percent
// - Counter advances only on the low-speed oscillator tick
// - Watchdog reset sets the watchdog reset flag bit 4
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int LS_DIV = LS_DIV_DEFAULT
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cpu_fetch,
  input  wire logic        cpu_data_access,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [15:0] area_limit_lo,
  input  wire logic [15:0] area_limit_hi,
  output logic             wdt_reset_req
);
  import wwdt_pkg::*;

  initial begin
    if (LS_DIV < 1) begin
      $error("LS_DIV must be at least 1");
    end
  end

  typedef enum logic [1:0] {WWDT_IDLE, WWDT_RESP} wwdt_bus_t;

  // Window threshold: period times (1 - open fraction)
  function automatic logic [17:0] close_end(input logic [2:0] per, input logic [1:0] win);
    logic [17:0] full;
    full = 18'h00400 << per;
    case (win)
      2'h0:    close_end = full - (full >> 2);
      2'h1:    close_end = full >> 1;
      2'h2:    close_end = full >> 2;
      default: close_end = 18'h00000;
    endcase
  endfunction

  // Registers
  logic [7:0]  option;
  logic [3:0]  control;
  logic [17:0] count;
  logic        first_done;
  logic        pend_fault;
  logic        flag;
  logic [15:0] div_cnt;
  logic [2:0]  rst_cnt;
  wwdt_bus_t   wstate;
  logic        aw_got;
  logic        w_got;
  logic [15:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] rdata;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [1:0]  bresp;

  logic [7:0]  next_option;
  logic [3:0]  next_control;
  logic [17:0] next_count;
  logic        next_first_done;
  logic        next_pend_fault;
  logic        next_flag;
  logic [15:0] next_div_cnt;
  logic [2:0]  next_rst_cnt;
  wwdt_bus_t   next_wstate;
  logic        next_aw_got;
  logic        next_w_got;
  logic [15:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic [31:0] next_rdata;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [1:0]  next_bresp;

  // Derived conditions
  logic        run_en;
  logic        ls_halted;
  logic        ls_tick;
  logic [17:0] ovf_count;
  logic        in_close;
  logic        wr_fire;
  logic        key_hit;
  logic        key_write;
  logic        area_bad;
  logic        exempt;
  logic        fault_now;

  assign run_en    = option[OPT_RUN_BIT];
  // Stop only possible when the lock option allows it
  assign ls_halted = ~option[OPT_LOCK_BIT] &
                     (control[CTL_OSC_STOP_BIT] | control[CTL_STANDBY_BIT]);
  assign ls_tick   = (div_cnt == 16'(LS_DIV - 1)) & ~ls_halted;
  assign ovf_count = 18'h00400 << option[OPT_PERIOD_LSB +: 3];
  assign in_close  = first_done &
                     (count < close_end(option[OPT_PERIOD_LSB +: 3], option[OPT_WIN_LSB +: 2]));
  assign wr_fire   = (wstate == WWDT_IDLE) & aw_got & w_got;
  assign key_hit   = (aw_addr == OFF_RESTART_KEY);
  assign key_write = wr_fire & key_hit & w_strb[0];
  assign exempt    = ((cpu_addr >= EXEMPT_A_LO) & (cpu_addr <= EXEMPT_A_HI)) |
                     (cpu_addr >= EXEMPT_B_LO);
  assign area_bad  = (cpu_addr < area_limit_lo) | (cpu_addr > area_limit_hi);
  // Illegal accesses only watched when running
  assign fault_now = run_en & ((cpu_fetch & area_bad) |
                               (cpu_data_access & area_bad & ~exempt));

  // Watchdog core next state
  always_comb begin
    next_count      = count;
    next_first_done = first_done;
    next_pend_fault = pend_fault;
    next_flag       = flag;
    next_div_cnt    = ls_halted ? div_cnt : (ls_tick ? 16'h0000 : div_cnt + 16'h0001);
    next_rst_cnt    = (rst_cnt != 3'h0) ? rst_cnt - 3'h1 : 3'h0;
    if (run_en && ls_tick) begin
      next_count = count + 18'h00001;
    end
    if (key_write && run_en) begin
      // Bad value, single-bit op or closed window all mean a fault
      if (w_data[7:0] != KEY_VALUE || control[CTL_BITOP_BIT] || in_close) begin
        next_pend_fault = 1'b1;
      end else begin
        next_count      = 18'h00000;
        next_first_done = 1'b1;
      end
    end
    if (fault_now) begin
      next_rst_cnt = 3'(RST_PULSE_CYCLES); // Access faults need no low-speed clock
      next_flag    = 1'b1;
    end
    // Deferred faults wait for the low-speed clock to run again
    if (pend_fault && !ls_halted) begin
      next_pend_fault = 1'b0;
      next_rst_cnt    = 3'(RST_PULSE_CYCLES);
      next_flag       = 1'b1;
    end
    if (run_en && ls_tick && next_count >= ovf_count && !(key_write && next_count == 18'h0)) begin
      next_rst_cnt = 3'(RST_PULSE_CYCLES);
      next_flag    = 1'b1;
      next_count   = 18'h00000;
      next_first_done = 1'b0;
    end
    if (rst_cnt == 3'h1) begin
      // Internal reset restarts the count and clears first_done
      next_count      = 18'h00000;
      next_first_done = 1'b0;
    end
  end

  // AXI4-Lite slave next state
  always_comb begin
    next_option   = option;
    next_control  = control;
    next_wstate   = wstate;
    next_aw_got   = aw_got;
    next_w_got    = w_got;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_rdata    = rdata;
    next_rvalid   = rvalid;
    next_rresp    = rresp;
    next_bresp    = bresp;
    if (s_axi_awvalid && !aw_got && wstate == WWDT_IDLE) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got && wstate == WWDT_IDLE) begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_wstate = WWDT_RESP;
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bresp  = AXI_OKAY;
      case (aw_addr)
        OFF_RESTART_KEY: ;
        OFF_OPTION:  if (w_strb[0]) next_option = w_data[7:0];
        OFF_CONTROL: if (w_strb[0]) next_control = w_data[3:0];
        OFF_STATUS:  ;
        OFF_COUNT:   ;
        default:     next_bresp = AXI_SLVERR;
      endcase
    end
    if (wstate == WWDT_RESP && s_axi_bready) begin
      next_wstate = WWDT_IDLE;
    end
    if (!rvalid && s_axi_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = AXI_OKAY;
      case (s_axi_araddr)
        OFF_RESTART_KEY: next_rdata = {24'h0, run_en ? KEY_READ_RUN : KEY_READ_IDLE};
        OFF_OPTION:      next_rdata = {24'h0, option};
        OFF_CONTROL:     next_rdata = {28'h0, control};
        OFF_STATUS:      next_rdata = {27'h0, flag, 4'h0};
        OFF_COUNT:       next_rdata = {14'h0, count};
        default: begin
          next_rdata = 32'h0;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // Status flag is sticky here; clearing belongs to the reset unit
  end

  // Registers of both groups
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option     <= OPT_RESET;
      control    <= 4'h0;
      count      <= 18'h00000;
      first_done <= 1'b0;
      pend_fault <= 1'b0;
      flag       <= 1'b0;
      div_cnt    <= 16'h0000;
      rst_cnt    <= 3'h0;
      wstate     <= WWDT_IDLE;
      aw_got     <= 1'b0;
      w_got      <= 1'b0;
      aw_addr    <= 16'h0000;
      w_data     <= 32'h0;
      w_strb     <= 4'h0;
      rdata      <= 32'h0;
      rvalid     <= 1'b0;
      rresp      <= AXI_OKAY;
      bresp      <= AXI_OKAY;
      wdt_reset_req <= 1'b0;
    end else begin
      option     <= next_option;
      control    <= next_control;
      count      <= next_count;
      first_done <= next_first_done;
      pend_fault <= next_pend_fault;
      flag       <= next_flag;
      div_cnt    <= next_div_cnt;
      rst_cnt    <= next_rst_cnt;
      wstate     <= next_wstate;
      aw_got     <= next_aw_got;
      w_got      <= next_w_got;
      aw_addr    <= next_aw_addr;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      rdata      <= next_rdata;
      rvalid     <= next_rvalid;
      rresp      <= next_rresp;
      bresp      <= next_bresp;
      wdt_reset_req <= (next_rst_cnt != 3'h0);
    end
  end

  // Ready only while idle so a held write is not taken twice
  assign s_axi_awready = (wstate == WWDT_IDLE) & ~aw_got;
  assign s_axi_wready  = (wstate == WWDT_IDLE) & ~w_got;
  assign s_axi_bvalid  = (wstate == WWDT_RESP);
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = ~rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // Watchdog fault, clear, read and count checks
  sequence s_bad_key;
    key_write && run_en && w_data[7:0] != KEY_VALUE && !ls_halted;
  endsequence
  AST_BADKEY_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bad_key |-> ##[1:3] wdt_reset_req) else $error("bad key gave no reset");
  AST_CLOSE_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    key_write && run_en && in_close && !ls_halted |-> ##[1:3] wdt_reset_req)
    else $error("closed window write gave no reset");
  AST_KEY_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    key_write && run_en && w_data[7:0] == KEY_VALUE && !in_close && !control[CTL_BITOP_BIT]
    |=> count <= 18'h00001) else $error("key did not clear");
  AST_READ_VALUE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && !rvalid && s_axi_araddr == OFF_RESTART_KEY
    |=> rdata[7:0] == (run_en ? KEY_READ_RUN : KEY_READ_IDLE)) else $error("bad key read");
  AST_HALT_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    ls_halted && !key_write && rst_cnt == 3'h0 |=> $stable(count)) else $error("count moved");
  AST_NO_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_en && !key_write && rst_cnt == 3'h0 |=> count == $past(count)) else $error("ran");
  AST_OVF_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    run_en && ls_tick && count + 18'h1 >= ovf_count && !key_write |=> wdt_reset_req)
    else $error("no overflow reset");
  AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wdt_reset_req) |-> flag) else $error("flag not set");
endmodule : wwdt_top

// file: tb/windowed_watchdog_timer_bench.sv
// Purpose: Self-checking bench for the windowed watchdog over AXI4-Lite
// Assumes: LS_DIV of 1, so one low-speed tick per aclk
// Notes:   Counting starts once the option register is written
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
  import wwdt_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [15:0] awaddr = 0, araddr = 0, cpu_addr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd_val;
  logic [3:0]  wstrb = 4'h1;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, rst_req;
  logic        cpu_fetch = 0, cpu_data = 0, rst_seen = 0;
  logic [15:0] lim_lo = 16'h0000, lim_hi = 16'h0FFF;
  int          err_total = 0, checked = 0;

  // Clock at 20 MHz
  always #25 aclk = ~aclk;
  // Latch reset requests at the quiet edge, between design updates
  always @(negedge aclk) if (rst_req) rst_seen = 1'b1;

  wwdt_top #(.LS_DIV(1)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_fetch(cpu_fetch),
    .cpu_data_access(cpu_data), .cpu_addr(cpu_addr), .area_limit_lo(lim_lo),
    .area_limit_hi(lim_hi), .wdt_reset_req(rst_req)
  );

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic hang(input string nm);
    $display("[FAIL] %s expected answer seen timeout", nm);
    err_total++;
    print_verdict();
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang("write");
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang("read");
  endtask

  // Bounded watch: expecting a reset ends early once it is seen
  task automatic watch(input int n, input logic exp, input string nm);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (exp && rst_seen) break;
    end
    chk(nm, {31'h0, exp}, {31'h0, rst_seen});
  endtask

  // Full reset and fresh option; the option is lost on every aresetn reset
  task automatic cfg(input logic [31:0] opt);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rst_seen = 1'b0;
    if (opt != 32'hFFFFFFFF) wr(OFF_OPTION, opt, resp);
  endtask

  function automatic logic [31:0] op(input int w, input int r, input int p, input int l);
    return 32'((w << OPT_WIN_LSB) | (r << OPT_RUN_BIT) | (p << OPT_PERIOD_LSB) | l);
  endfunction

  // One-cycle CPU access seen by the illegal-access detector
  task automatic acc(input logic f, input logic d, input logic [15:0] a);
    @(posedge aclk);
    cpu_fetch <= f;
    cpu_data <= d;
    cpu_addr <= a;
    @(posedge aclk);
    cpu_fetch <= 1'b0;
    cpu_data <= 1'b0;
  endtask

  // Hang guard well above the expected run length
  initial begin
    repeat (100000) @(posedge aclk);
    hang("run");
  end

  initial begin
    int n, cl;
    cfg(32'hFFFFFFFF);
    rd(OFF_RESTART_KEY, rd_val, resp);
    chk("key_reset", {24'h0, KEY_READ_IDLE}, rd_val);
    wr(OFF_OPTION, op(3, 1, 1, 0), resp);
    wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
    chk("key_resp", {30'h0, AXI_OKAY}, {30'h0, resp});
    rd(OFF_RESTART_KEY, rd_val, resp);
    chk("key_read", {24'h0, KEY_READ_RUN}, rd_val);
    rd(16'h0014, rd_val, resp);
    chk("rd_unmapped", {30'h0, AXI_SLVERR}, {30'h0, resp});
    wr(16'h0020, 32'h0, resp);
    chk("wr_unmapped", {30'h0, AXI_SLVERR}, {30'h0, resp});
    $display("test regs done");
    // Wrong key value, then the cause flag
    cfg(op(3, 1, 1, 0));
    wr(OFF_RESTART_KEY, 32'h55, resp);
    watch(20, 1'b1, "nonkey");
    repeat (8) @(posedge aclk);
    rd(OFF_STATUS, rd_val, resp);
    chk("reset_flag", 32'h1, {31'h0, rd_val[STS_RESET_FLAG]});
    $display("test nonkey done");
    // Overflow period for codes 0 to 2; slack covers the two-tick uncertainty
    for (int p = 0; p < 3; p++) begin
      cfg(op(3, 1, p, 0));
      n = 1 << (10 + p);
      watch(n - 8, 1'b0, "before_ovf");
      watch(24, 1'b1, "overflow");
    end
    $display("test overflow done");
    // Window fractions: write just inside close, then just inside open
    for (int w = 0; w < 4; w++) begin
      n = 2048;
      cl = n * (3 - w) / 4;
      if (w < 3) begin
        cfg(op(w, 1, 1, 0));
        wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
        watch(cl - 40, 1'b0, "first_key");
        wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
        watch(20, 1'b1, "closed_write");
      end
      cfg(op(w, 1, 1, 0));
      wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
      watch(cl + 100, 1'b0, "first_key2");
      wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
      watch(n - 40, 1'b0, "open_write");
    end
    $display("test window done");
    // Key write just ahead of overflow still clears
    cfg(op(3, 1, 0, 0));
    wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
    watch(1000, 1'b0, "pre_late");
    wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
    watch(200, 1'b0, "late_key");
    // Single-bit access marker
    cfg(op(3, 1, 1, 0));
    wr(OFF_CONTROL, 32'h1 << CTL_BITOP_BIT, resp);
    wr(OFF_RESTART_KEY, {24'h0, KEY_VALUE}, resp);
    watch(20, 1'b1, "bit_access");
    $display("test key done");
    // Illegal accesses, exempt ranges and the run option
    cfg(op(3, 1, 3, 0));
    acc(1'b0, 1'b1, EXEMPT_A_LO);
    acc(1'b0, 1'b1, EXEMPT_A_HI);
    acc(1'b0, 1'b1, EXEMPT_B_LO);
    acc(1'b0, 1'b1, 16'hFFFF);
    acc(1'b1, 1'b0, 16'h0100);
    watch(20, 1'b0, "exempt");
    acc(1'b0, 1'b1, 16'h1234);
    watch(20, 1'b1, "data_out");
    cfg(op(3, 1, 3, 0));
    acc(1'b1, 1'b0, 16'h2000);
    watch(20, 1'b1, "fetch_out");
    cfg(op(3, 0, 0, 0));
    acc(1'b0, 1'b1, 16'h2000);
    acc(1'b1, 1'b0, 16'h2000);
    watch(1200, 1'b0, "run_off");
    $display("test access done");
    // Standby and oscillator stop hold the count without clearing it under lock option 0
    for (int k = 0; k < 2; k++) begin
      cfg(op(3, 1, 0, 0));
      wr(OFF_CONTROL, 32'h1 << (k ? CTL_OSC_STOP_BIT : CTL_STANDBY_BIT), resp);
      watch(1500, 1'b0, "halted");
      wr(OFF_CONTROL, 32'h0, resp);
      watch(900, 1'b0, "resume_early");
      watch(220, 1'b1, "resume_ovf");
    end
    cfg(op(3, 1, 0, 1));
    wr(OFF_CONTROL, 32'h1 << CTL_STANDBY_BIT, resp);
    watch(1100, 1'b1, "lock_runs");
    $display("test standby done");
    print_verdict();
  end
endmodule // windowed_watchdog_timer_bench
